// File: design/drs_pkg.sv
// Shared constants, types and decode functions for the DMA request selector
package drs_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NCH    = 4;
  localparam int EXT_CH = 2;
  localparam int NSRC   = 5;

  // ****************************************************************
  // Request source select codes
  // ****************************************************************
  localparam logic [3:0] RS_EXT_DUAL   = 4'h0;
  localparam logic [3:0] RS_EXT_SA_OUT = 4'h2;
  localparam logic [3:0] RS_EXT_SA_IN  = 4'h3;
  localparam logic [3:0] RS_SER_TX     = 4'h8;
  localparam logic [3:0] RS_SER_RX     = 4'h9;
  localparam logic [3:0] RS_FSER_TX    = 4'ha;
  localparam logic [3:0] RS_FSER_RX    = 4'hb;
  localparam logic [3:0] RS_CAP_EE     = 4'hc;
  localparam logic [3:0] RS_CAP_EP     = 4'hd;
  localparam logic [3:0] RS_CAP_PE     = 4'he;

  // ****************************************************************
  // Physical peripheral request lines
  // ****************************************************************
  localparam logic [2:0] SRC_SER_TX  = 3'h0;
  localparam logic [2:0] SRC_SER_RX  = 3'h1;
  localparam logic [2:0] SRC_FSER_TX = 3'h2;
  localparam logic [2:0] SRC_FSER_RX = 3'h3;
  localparam logic [2:0] SRC_CAP     = 3'h4;

  // ****************************************************************
  // Priority modes and orders (position 0 in the low bits)
  // ****************************************************************
  localparam logic [1:0] PRI_FIX0  = 2'h0;
  localparam logic [1:0] PRI_FIX1  = 2'h1;
  localparam logic [1:0] PRI_FIX2  = 2'h2;
  localparam logic [1:0] PRI_RR    = 2'h3;
  localparam logic [1:0] PRI_RESET = PRI_FIX0;
  localparam logic [7:0] ORDER_FIX0 = 8'he4;
  localparam logic [7:0] ORDER_FIX1 = 8'h78;
  localparam logic [7:0] ORDER_FIX2 = 8'hd2;
  localparam logic [1:0] RR_TOP_RESET = 2'h0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic EXT_PIN_IDLE = 1'b1;

  typedef enum logic [0:0] {
    DRS_IDLE = 1'b0,
    DRS_BUSY = 1'b1
  } drs_state_t;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Returns {valid, line index} for a peripheral request code
  function automatic logic [3:0] periph_src(input logic [3:0] code);
    logic [3:0] r;
    r = 4'h0;
    unique case (code)
      RS_SER_TX:  r = {1'b1, SRC_SER_TX};
      RS_SER_RX:  r = {1'b1, SRC_SER_RX};
      RS_FSER_TX: r = {1'b1, SRC_FSER_TX};
      RS_FSER_RX: r = {1'b1, SRC_FSER_RX};
      RS_CAP_EE,
      RS_CAP_EP,
      RS_CAP_PE:  r = {1'b1, SRC_CAP};
      default:    r = 4'h0;
    endcase
    return r;
  endfunction

  function automatic logic is_ext(input logic [3:0] code);
    return (code == RS_EXT_DUAL) || (code == RS_EXT_SA_OUT)
        || (code == RS_EXT_SA_IN);
  endfunction

  // Channel that holds position pos (0 = highest) in the given mode
  function automatic logic [1:0] chan_at(input logic [1:0] mode,
                                         input logic [1:0] top,
                                         input logic [1:0] pos);
    logic [1:0] c;
    c = 2'h0;
    unique case (mode)
      PRI_FIX0: c = ORDER_FIX0[{pos, 1'b0} +: 2];
      PRI_FIX1: c = ORDER_FIX1[{pos, 1'b0} +: 2];
      PRI_FIX2: c = ORDER_FIX2[{pos, 1'b0} +: 2];
      PRI_RR:   c = 2'(top + pos);
    endcase
    return c;
  endfunction

endpackage

// File: design/drs_if.sv
// Link between the DMA request selector and its request sources
interface drs_if;
  logic [drs_pkg::EXT_CH-1:0] ext_transfer_request_n;
  logic [drs_pkg::NSRC-1:0]   source_request;
  logic                       capture_request_enable_hi;
  logic                       capture_request_enable_lo;
  logic [drs_pkg::NSRC-1:0]   request_clear;

  modport dev (
    input  ext_transfer_request_n,
    input  source_request,
    input  capture_request_enable_hi,
    input  capture_request_enable_lo,
    output request_clear
  );

  modport req (
    output ext_transfer_request_n,
    output source_request,
    output capture_request_enable_hi,
    output capture_request_enable_lo,
    input  request_clear
  );
endinterface

// File: design/drs_requester.sv
// Request source end: external request pin and peripheral request lines
module drs_requester
(
  input  wire logic                       mclk_i,
  input  wire logic                       resetn_i,
  drs_if.req                              link,
  input  wire logic [drs_pkg::EXT_CH-1:0] ext_request_i,
  input  wire logic [drs_pkg::NSRC-1:0]   periph_event_i,
  input  wire logic [drs_pkg::NSRC-1:0]   periph_dma_enable_i,
  input  wire logic                       capture_enable_hi_i,
  input  wire logic                       capture_enable_lo_i,
  output logic      [drs_pkg::NSRC-1:0]   periph_request_o
);
  import drs_pkg::*;

  logic [EXT_CH-1:0] pin_q;
  logic [NSRC-1:0]   line_q;
  logic [NSRC-1:0]   line_d;
  logic [NSRC-1:0]   line_en;
  logic              cap_en_hi_q;
  logic              cap_en_lo_q;
  logic              cap_any;

  // ****************************************************************
  // Request lines
  // ****************************************************************
  assign cap_any = capture_enable_hi_i | capture_enable_lo_i;

  // Capture is gated by its own pair of enables, not the generic one
  assign line_en = {cap_any, periph_dma_enable_i[NSRC-2:0]};

  // A new event in the clear cycle wins, so it is never lost
  assign line_d = ((line_q & ~link.request_clear) | (periph_event_i & line_en))
                & line_en;

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pin_q       <= {EXT_CH{EXT_PIN_IDLE}};
      line_q      <= '0;
      cap_en_hi_q <= 1'b0;
      cap_en_lo_q <= 1'b0;
    end
    else
    begin
      pin_q       <= ~ext_request_i;
      line_q      <= line_d;
      cap_en_hi_q <= capture_enable_hi_i;
      cap_en_lo_q <= capture_enable_lo_i;
    end
  end

  assign link.ext_transfer_request_n    = pin_q;
  assign link.source_request            = line_q;
  assign link.capture_request_enable_hi = cap_en_hi_q;
  assign link.capture_request_enable_lo = cap_en_lo_q;
  assign periph_request_o               = line_q;

endmodule

// File: design/drs_arbiter.sv
// DMA request selection, qualification and channel arbitration
module drs_arbiter
(
  input  wire logic                             mclk_i,
  input  wire logic                             resetn_i,
  drs_if.dev                                    link,
  input  wire logic                             master_enable_i,
  input  wire logic                             nmi_flag_i,
  input  wire logic                             address_error_flag_i,
  input  wire logic                             priority_mode_hi_i,
  input  wire logic                             priority_mode_lo_i,
  input  wire logic [drs_pkg::NCH-1:0]          channel_enable_i,
  input  wire logic [drs_pkg::NCH-1:0]          transfer_end_flag_i,
  input  wire logic [drs_pkg::NCH-1:0]          burst_mode_i,
  input  wire logic [drs_pkg::NCH-1:0][3:0]     request_source_select_i,
  input  wire logic [drs_pkg::EXT_CH-1:0]       request_sense_select_i,
  input  wire logic                             unit_done_i,
  input  wire logic                             last_unit_i,
  output logic                                  grant_valid_o,
  output logic      [1:0]                       grant_channel_o,
  output logic      [drs_pkg::NCH-1:0]          request_pending_o
);
  import drs_pkg::*;

  drs_state_t        state_q;
  logic [1:0]        pri_q;
  logic [1:0]        top_q;
  logic              grant_valid_q;
  logic [1:0]        grant_ch_q;
  logic [NCH-1:0]    pending_q;
  logic [NSRC-1:0]   clear_q;
  logic [EXT_CH-1:0] pin_prev_q;
  logic [EXT_CH-1:0] held_q;

  logic [NSRC-1:0]   line;
  logic [NCH-1:0]    accept;
  logic [NCH-1:0]    enabled;
  logic [NCH-1:0]    raw;
  logic [NCH-1:0]    req;
  logic [NCH-1:0][3:0] src;
  logic [EXT_CH-1:0] fall;
  logic [EXT_CH-1:0] held_d;
  logic [EXT_CH-1:0] start_ext;
  logic              pick_ok;
  logic [1:0]        pick_ch;
  logic              start;
  logic              unit_end;
  logic              stay;
  logic [NSRC-1:0]   clear_d;
  logic [3:0]        g_src;

  // ****************************************************************
  // Source lines and qualification
  // ****************************************************************
  // Lines being cleared are masked for one cycle: the source drops its
  // line one edge after the clear, which would otherwise re-trigger.
  assign line = {link.source_request[SRC_CAP]
                 & (link.capture_request_enable_hi
                    | link.capture_request_enable_lo),
                 link.source_request[NSRC-2:0]}
              & ~clear_q;

  assign accept  = ~transfer_end_flag_i
                 & {NCH{~nmi_flag_i & ~address_error_flag_i}};
  assign enabled = accept & channel_enable_i
                 & {NCH{master_enable_i}};

  // Selection never looks at where data is read or written
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      src[c] = periph_src(request_source_select_i[c]);
      raw[c] = src[c][3] & line[src[c][2:0]];
      if (c < EXT_CH)
      begin
        if (is_ext(request_source_select_i[c]))
        begin
          raw[c] = request_sense_select_i[c] ? held_q[c]
                                             : ~link.ext_transfer_request_n[c];
        end
      end
    end
  end

  assign req = raw & enabled;

  // ****************************************************************
  // External edge capture
  // ****************************************************************
  assign fall = pin_prev_q & ~link.ext_transfer_request_n;

  always_comb
  begin
    for (int c = 0; c < EXT_CH; c++)
    begin
      start_ext[c] = start && (pick_ch == 2'(c));
    end
  end

  // Held while disabled, dropped on error; a fresh edge wins
  assign held_d = (held_q & ~start_ext
                   & {EXT_CH{~nmi_flag_i & ~address_error_flag_i}})
                | (fall & request_sense_select_i & accept[EXT_CH-1:0]);

  // ****************************************************************
  // Priority pick
  // ****************************************************************
  always_comb
  begin
    pick_ok = 1'b0;
    pick_ch = 2'h0;
    for (int p = NCH - 1; p >= 0; p--)
    begin
      if (req[chan_at(pri_q, top_q, 2'(p))])
      begin
        pick_ok = 1'b1;
        pick_ch = chan_at(pri_q, top_q, 2'(p));
      end
    end
  end

  assign start    = (state_q == DRS_IDLE) && pick_ok;
  assign unit_end = (state_q == DRS_BUSY) && unit_done_i;
  assign g_src    = src[grant_ch_q];

  // Burst keeps the bus until the last unit or loss of the request
  assign stay = burst_mode_i[grant_ch_q] && !last_unit_i
             && req[grant_ch_q];

  always_comb
  begin
    clear_d = '0;
    if (unit_end && g_src[3] && (!burst_mode_i[grant_ch_q] || last_unit_i))
    begin
      clear_d[g_src[2:0]] = 1'b1;
    end
  end

  // ****************************************************************
  // State
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pri_q      <= PRI_RESET;
      pin_prev_q <= {EXT_CH{EXT_PIN_IDLE}};
      held_q     <= '0;
      pending_q  <= '0;
      clear_q    <= '0;
    end
    else
    begin
      pri_q      <= {priority_mode_hi_i, priority_mode_lo_i};
      pin_prev_q <= link.ext_transfer_request_n;
      held_q     <= held_d;
      pending_q  <= raw;
      clear_q    <= clear_d;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q       <= DRS_IDLE;
      grant_valid_q <= 1'b0;
      grant_ch_q    <= 2'h0;
      top_q         <= RR_TOP_RESET;
    end
    else
    begin
      unique case (state_q)
        DRS_IDLE:
        begin
          if (start)
          begin
            state_q       <= DRS_BUSY;
            grant_valid_q <= 1'b1;
            grant_ch_q    <= pick_ch;
          end
          else if (raw == '0)
          begin
            top_q <= RR_TOP_RESET;
          end
        end
        DRS_BUSY:
        begin
          if (unit_done_i)
          begin
            if (pri_q == PRI_RR)
            begin
              top_q <= 2'(grant_ch_q + 2'h1);
            end
            if (!stay)
            begin
              state_q       <= DRS_IDLE;
              grant_valid_q <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign link.request_clear = clear_q;
  assign grant_valid_o      = grant_valid_q;
  assign grant_channel_o    = grant_ch_q;
  assign request_pending_o  = pending_q;

endmodule

// File: verification/drs_assertions.sv
// Concurrent checks on the request link and the grant outputs
module drs_assertions
(
  input wire logic                       mclk_i,
  input wire logic                       resetn_i,
  input wire logic [drs_pkg::EXT_CH-1:0] ext_transfer_request_n,
  input wire logic [drs_pkg::NSRC-1:0]   source_request,
  input wire logic                       capture_request_enable_hi,
  input wire logic                       capture_request_enable_lo,
  input wire logic [drs_pkg::NSRC-1:0]   request_clear,
  input wire logic                       master_enable_i,
  input wire logic                       unit_done_i,
  input wire logic                       last_unit_i,
  input wire logic                       grant_valid_o,
  input wire logic [1:0]                 grant_channel_o,
  input wire logic [drs_pkg::NCH-1:0]    request_pending_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import drs_pkg::*;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  // *****
  // Sequences
  // *****
  sequence s_unit_end;
    grant_valid_o && unit_done_i && last_unit_i;
  endsequence

  sequence s_grant_start;
    $rose(grant_valid_o);
  endsequence

  sequence s_capture_off;
    !capture_request_enable_hi && !capture_request_enable_lo;
  endsequence

  // *****
  // Checks
  // *****
  AST_CLEAR_ONE_CYCLE: assert property (
    (|request_clear) |=> (request_clear == '0))
    else $error("request clear held past one cycle");

  AST_CLEAR_CAUSE: assert property (
    (|request_clear) |-> $past(unit_done_i) && $past(grant_valid_o))
    else $error("request clear without a finished unit");

  AST_CLEAR_SINGLE: assert property (
    $onehot0(request_clear))
    else $error("several request lines cleared at once");

  AST_UNIT_END_DROP: assert property (
    s_unit_end |=> !grant_valid_o)
    else $error("grant kept after the last unit");

  AST_GRANT_HOLD: assert property (
    grant_valid_o && !unit_done_i |=> grant_valid_o && $stable(grant_channel_o))
    else $error("grant changed in mid unit");

  AST_GRANT_ENABLED: assert property (
    s_grant_start |-> $past(master_enable_i))
    else $error("grant with master enable clear");

  AST_GRANT_PENDING: assert property (
    s_grant_start |-> request_pending_o[grant_channel_o])
    else $error("grant to a channel with no request");

  AST_CAPTURE_OFF: assert property (
    s_capture_off[*2] |-> !source_request[SRC_CAP])
    else $error("capture request kept with both enables clear");

  AST_PIN_IDLE: assert property (
    !$past(resetn_i) |-> ext_transfer_request_n == 2'b11)
    else $error("request pin low right after reset");
endmodule

// File: verification/test_dma_request_select_and_channel_arbiter.sv
// Self-checking bench joining both ends of the DMA request selector
module test_dma_request_select_and_channel_arbiter;
  timeunit 1ns;
  timeprecision 1ps;
  import drs_pkg::*;

  logic                mclk_i;
  logic                resetn_i;
  logic [EXT_CH-1:0]   ext_request_i;
  logic [NSRC-1:0]     periph_event_i;
  logic [NSRC-1:0]     periph_dma_enable_i;
  logic                capture_enable_hi_i;
  logic                capture_enable_lo_i;
  logic [NSRC-1:0]     periph_request_o;
  logic                master_enable_i;
  logic                nmi_flag_i;
  logic                address_error_flag_i;
  logic                priority_mode_hi_i;
  logic                priority_mode_lo_i;
  logic [NCH-1:0]      channel_enable_i;
  logic [NCH-1:0]      transfer_end_flag_i;
  logic [NCH-1:0]      burst_mode_i;
  logic [NCH-1:0][3:0] request_source_select_i;
  logic [EXT_CH-1:0]   request_sense_select_i;
  logic                unit_done_i;
  logic                last_unit_i;
  logic                grant_valid_o;
  logic [1:0]          grant_channel_o;
  logic [NCH-1:0]      request_pending_o;
  logic [3:0]          want;
  int                  failures;
  int                  total_checks;
  int                  mode;
  int                  top;
  int                  c;
  int                  exp_q [$];
  int                  ord [3][4] = '{'{0,1,2,3}, '{0,2,3,1}, '{2,0,1,3}};

  initial mclk_i = 1'b0;
  always #5 mclk_i = ~mclk_i;

  drs_if link_if ();

  drs_requester i_drs_requester (.mclk_i, .resetn_i, .link(link_if),
    .ext_request_i, .periph_event_i, .periph_dma_enable_i,
    .capture_enable_hi_i, .capture_enable_lo_i, .periph_request_o);

  drs_arbiter i_drs_arbiter (.mclk_i, .resetn_i, .link(link_if),
    .master_enable_i, .nmi_flag_i, .address_error_flag_i,
    .priority_mode_hi_i, .priority_mode_lo_i, .channel_enable_i,
    .transfer_end_flag_i, .burst_mode_i, .request_source_select_i,
    .request_sense_select_i, .unit_done_i, .last_unit_i,
    .grant_valid_o, .grant_channel_o, .request_pending_o);

  drs_assertions i_drs_assertions (.mclk_i, .resetn_i,
    .ext_transfer_request_n(link_if.ext_transfer_request_n),
    .source_request(link_if.source_request),
    .capture_request_enable_hi(link_if.capture_request_enable_hi),
    .capture_request_enable_lo(link_if.capture_request_enable_lo),
    .request_clear(link_if.request_clear), .master_enable_i,
    .unit_done_i, .last_unit_i, .grant_valid_o, .grant_channel_o,
    .request_pending_o);

  // *****
  // Helpers and reference model
  // *****
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Winner among requesting channels under the current order
  function automatic int pick(input logic [3:0] r);
    int ch;
    pick = 0;
    for (int p = 3; p >= 0; p--)
    begin
      ch = (mode == 3) ? (top + p) % 4 : ord[mode][p];
      if (r[ch])
        pick = ch;
    end
  endfunction

  // Waits for a grant, checks it, then ends one unit on it
  task automatic serve(input int ch, input bit drop);
    int   n;
    logic keep;
    n = 0;
    while (grant_valid_o !== 1'b1 && n < 10)
    begin
      tick(1);
      n++;
    end
    check(grant_valid_o, 8'h01);
    check(grant_channel_o, ch[1:0]);
    keep = burst_mode_i[ch[1:0]] && !last_unit_i;
    unit_done_i = 1'b1;
    if (drop)
      ext_request_i = '0;
    tick(1);
    unit_done_i = 1'b0;
    // The drop lasts one cycle only when a request, on this or another channel, is still waiting
    check(grant_valid_o, {7'h00, keep});
    tick(1);
  endtask

  task automatic set_mode(input int m);
    mode = m;
    {priority_mode_hi_i, priority_mode_lo_i} = 2'(m);
    tick(2);
  endtask

  task automatic pulse(input logic [NSRC-1:0] ev);
    periph_event_i = ev;
    tick(1);
    periph_event_i = '0;
  endtask

  // *****
  // Tests
  // *****
  initial
  begin
    resetn_i = 1'b0;
    {ext_request_i, periph_event_i, request_sense_select_i} = '0;
    {nmi_flag_i, address_error_flag_i, unit_done_i} = '0;
    {transfer_end_flag_i, burst_mode_i} = '0;
    {priority_mode_hi_i, priority_mode_lo_i} = 2'b00;
    {master_enable_i, last_unit_i} = 2'b11;
    {capture_enable_hi_i, capture_enable_lo_i} = 2'b10;
    periph_dma_enable_i = 5'h1f;
    channel_enable_i = 4'hf;
    request_source_select_i = {4'h8, 4'h9, 4'ha, 4'hb};
    {failures, total_checks, mode, top} = '0;
    void'($urandom(22791));
    tick(6);
    resetn_i = 1'b1;
    tick(1);
    check(link_if.ext_transfer_request_n, 8'h03);
    // Serial sources only raise requests; data endpoints lie elsewhere
    request_source_select_i = {RS_FSER_RX, RS_FSER_TX,
                               RS_SER_RX, RS_SER_TX};
    for (int m = 0; m < 4; m++)
    begin
      set_mode(m);
      repeat (4)
      begin
        want = 4'($urandom_range(15, 1));
        pulse({1'b0, want});
        while (want != 4'h0)
        begin
          c = pick(want);
          want[c] = 1'b0;
          if (mode == 3)
            top = (c + 1) % 4;
          exp_q.push_back(c);
        end
        while (exp_q.size() > 0)
          serve(exp_q.pop_front(), 1'b0);
        tick(3);
        check(periph_request_o, 8'h00);
        top = 0;
      end
      $display("test order %0d done", m);
    end
    set_mode(0);
    request_source_select_i = {4'h1, 4'h1, RS_CAP_EE, 4'h1};
    burst_mode_i = 4'h2;
    last_unit_i = 1'b0;
    pulse(5'h10);
    serve(1, 1'b0);
    serve(1, 1'b0);
    check(periph_request_o, 8'h10);
    last_unit_i = 1'b1;
    serve(1, 1'b0);
    tick(1);
    check(periph_request_o, 8'h00);
    burst_mode_i = '0;
    $display("test burst done");
    request_source_select_i = {4'h1, 4'h1, 4'h1, RS_SER_TX};
    for (int k = 0; k < 6; k++)
    begin
      master_enable_i = (k != 0);
      channel_enable_i = (k == 1) ? 4'he : 4'hf;
      transfer_end_flag_i = {3'h0, k == 2};
      nmi_flag_i = (k == 3);
      address_error_flag_i = (k == 4);
      periph_dma_enable_i = (k == 5) ? 5'h1e : 5'h1f;
      pulse(5'h01);
      tick(6);
      check(grant_valid_o, 8'h00);
      check(request_pending_o, {7'h00, k != 5});
      {master_enable_i, nmi_flag_i, address_error_flag_i} = 3'b100;
      channel_enable_i = 4'hf;
      transfer_end_flag_i = '0;
      periph_dma_enable_i = 5'h1f;
      if (k < 5)
        serve(0, 1'b0);
    end
    $display("test enables done");
    set_mode(2);
    request_source_select_i = {RS_CAP_PE, 4'h1, RS_CAP_EP, RS_CAP_EE};
    {capture_enable_hi_i, capture_enable_lo_i} = 2'($urandom_range(3, 1));
    pulse(5'h10);
    serve(pick(4'hb), 1'b0);
    tick(6);
    check(grant_valid_o, 8'h00);
    master_enable_i = 1'b0;
    pulse(5'h10);
    tick(3);
    check(request_pending_o, 8'h0b);
    {capture_enable_hi_i, capture_enable_lo_i} = 2'h0;
    tick(3);
    check(request_pending_o, 8'h00);
    master_enable_i = 1'b1;
    $display("test capture done");
    set_mode(0);
    request_source_select_i = {4'h1, 4'h1, RS_EXT_SA_IN, RS_EXT_DUAL};
    request_sense_select_i = 2'b01;
    ext_request_i = 2'b01;
    serve(0, 1'b0);
    tick(6);
    check(grant_valid_o, 8'h00);
    request_sense_select_i = 2'h0;
    serve(0, 1'b0);
    serve(0, 1'b1);
    ext_request_i = 2'h2;
    serve(1, 1'b1);
    tick(4);
    check(grant_valid_o, 8'h00);
    $display("test external done");
    end_of_test();
  end

  // Cuts a hang short well past the expected run length
  initial
  begin
    #100us;
    failures++;
    end_of_test();
  end
endmodule
